// >>> core/bbsc_core.sv
// bus back-off, snoop lookup and snoop write-back sequencer
//
// Contract
// - sampled back-off floats the bus next clock; hold lasts until negation
// - a cycle cut by back-off is re-run whole after back-off negates
// - burst ready together with back-off is ignored with its data
// - a burst read cut by back-off never installs its line
// - clean hit asserts match and invalidates when drop was high
// - dirty hit asserts match and dirty, holds dirty, refuses snoops
// - snoop write-back burst starts at quadword zero of the line
// - after write-back line goes invalid on drop, else shared
// - snoop also compared to fill buffer and write-back buffer
// - dirty hit answers in the second clock after the strobe
// - write-back is the first cycle once the bus is regained
// - address float next clock; strobe not before second edge
// - write-back runs under address hold, strobe two clocks after dirty
// - fill finishes first; one idle clock before write-back strobe
// - snooped fill still feeds core; dropped or installed shared
// - even parity on snoop address and parity bit, fault on error
// - system-management level set one clock before write-back strobe
// - level raised one clock before a main memory write-back
// - level asserted one clock before a system-management cycle
// - system-management pin floats in bus hold with the bus
`timescale 1ns/1ps
module bbsc_core
    import bbsc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire bbsc_pin_type pins_i,
    input wire logic bus_release_grant_i,
    input wire logic cyc_req_valid_i,
    input wire bbsc_req_type cyc_req_i,
    output logic cyc_req_ready_o,
    output logic cyc_done_o,
    input wire logic mark_valid_i,
    input wire bbsc_mark_type mark_i,
    output logic mark_ready_o,
    input wire logic [DATA_W-1:0] wr_data_i,
    output logic [BEAT_W-1:0] beat_o,
    output logic rd_valid_o,
    output logic [DATA_W-1:0] rd_data_o,
    output logic address_strobe_b_o,
    output logic [ADDR_HI:QW_LO] addr_o,
    output logic addr_oe_o,
    output logic ctl_oe_o,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic sys_mgmt_active_b_o,
    output logic sys_mgmt_oe_o,
    output logic snoop_match_b_o,
    output logic snoop_match_dirty_b_o,
    output logic addr_parity_fault_b_o
);
    bbsc_pin_type pins_s1_reg;
    bbsc_pin_type pins_s_reg;
    bbsc_seq_type state_reg;
    bbsc_seq_type state_next;
    bbsc_cyc_type cur_reg;
    bbsc_cyc_type saved_reg;
    bbsc_cyc_type load_cyc;
    bbsc_line_type rd_line;
    bbsc_line_type wr_line;
    logic [BEAT_W-1:0] beat_reg;
    logic burst_reg;
    logic policy_reg;
    logic restart_reg;
    logic wb_pend_reg;
    logic dirty_reg;
    logic match_reg;
    logic par_fault_reg;
    logic [ADDR_HI:LINE_LO] wb_line_reg;
    logic wb_smm_reg;
    logic wb_drop_reg;
    logic fill_snooped_reg;
    logic fill_drop_reg;
    logic snp1_reg;
    logic [ADDR_HI:LINE_LO] snp_addr_reg;
    logic snp_inv_reg;
    logic snp_par_reg;
    logic smm_level_reg;
    logic rd_valid_reg;
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] data_out_reg;
    logic [IDX_W-1:0] wr_idx;

    // pins are resampled twice before use
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pins_s1_reg <= '1;
            pins_s_reg <= '1;
        end else begin
            pins_s1_reg <= pins_i;
            pins_s_reg <= pins_s1_reg;
        end
    end

    wire logic back_off_request_s = !pins_s_reg.back_off_b;
    wire logic burst_ready_s = !pins_s_reg.burst_ready_b;
    wire logic addr_float_request_s = pins_s_reg.addr_float;
    wire logic strobe_s = !pins_s_reg.snoop_strobe_b;
    wire logic bus_hold = back_off_request_s || bus_release_grant_i;
    wire logic bus_free = !bus_hold;
    wire logic in_cycle = (state_reg != SQ_IDLE);
    wire logic abort = in_cycle && back_off_request_s;
    wire logic data_beat = (state_reg == SQ_DATA) && burst_ready_s && !back_off_request_s;
    wire logic first_beat = (beat_reg == BEAT_FIRST);
    // cacheable level taken at the first beat of every read run, re-runs too
    wire logic ken_now = !pins_s_reg.cacheable_b;
    wire logic burst_now = cur_reg.wb ||
        (first_beat ? (!cur_reg.write && ken_now) : burst_reg);
    wire logic last_beat = data_beat && (!burst_now || beat_reg == BEAT_LAST);
    wire logic wb_done = last_beat && cur_reg.wb;
    wire logic fill_done = last_beat && !cur_reg.write && !cur_reg.wb &&
        burst_now;
    wire logic policy_now = first_beat ? pins_s_reg.write_policy : policy_reg;

    // request selection: write-back first, then a re-run, then new work
    wire logic take_wb = (state_reg == SQ_IDLE) && bus_free && wb_pend_reg;
    wire logic take_restart = (state_reg == SQ_IDLE) && bus_free &&
        restart_reg && !wb_pend_reg && (saved_reg.wb || !addr_float_request_s);
    wire logic take_req = (state_reg == SQ_IDLE) && bus_free && !addr_float_request_s &&
        !wb_pend_reg && !restart_reg && cyc_req_valid_i;
    wire logic take_any = take_wb || take_restart || take_req;
    wire bbsc_cyc_type wb_cyc = '{addr: {wb_line_reg, WB_START_QW},
        write: 1'b1, smm: wb_smm_reg, wb: 1'b1};
    wire bbsc_cyc_type req_cyc = '{addr: cyc_req_i.addr,
        write: cyc_req_i.write, smm: cyc_req_i.smm, wb: 1'b0};
    assign load_cyc = take_wb ? wb_cyc :
        (take_restart ? saved_reg : req_cyc);

    // snoop acceptance and lookup, answer lands two clocks after strobe
    wire logic snoop_take = strobe_s && (bus_hold || addr_float_request_s) && !dirty_reg;
    wire logic [IDX_W-1:0] snp_idx = snp_addr_reg[LINE_LO+IDX_W-1:LINE_LO];
    wire logic [TAG_W-1:0] snp_tag = snp_addr_reg[ADDR_HI:LINE_LO+IDX_W];
    wire logic cache_hit = snp1_reg && (rd_line.state != ST_INV) &&
        (rd_line.tag == snp_tag);
    wire logic hit_mod = cache_hit && (rd_line.state == ST_MOD);
    wire logic hit_clean = cache_hit && (rd_line.state != ST_MOD);
    wire logic fill_busy = !cur_reg.write && !cur_reg.wb &&
        (in_cycle || restart_reg);
    wire logic fill_hit = snp1_reg && fill_busy &&
        (cur_reg.addr[ADDR_HI:LINE_LO] == snp_addr_reg);
    wire logic wbuf_hit = snp1_reg && wb_pend_reg &&
        (wb_line_reg == snp_addr_reg);
    wire logic snoop_any = cache_hit || fill_hit || wbuf_hit;
    wire logic par_err = ^{pins_s_reg.addr, pins_s_reg.parity_bit};
    wire logic fill_drop = fill_drop_reg || (fill_hit && snp_inv_reg);
    wire logic fill_snooped = fill_snooped_reg || fill_hit;
    wire logic fill_install = fill_done && !fill_drop;

    // line store write port, snoop invalidate has priority
    wire logic wr_inv = hit_clean && snp_inv_reg;
    wire logic wr_busy = wr_inv || wb_done || fill_install;
    wire logic wr_mark = mark_valid_i && !wr_busy;
    wire logic [1:0] fill_state = (fill_snooped || !policy_now) ?
        ST_SHR : ST_EXC;
    wire logic [1:0] wb_state = wb_drop_reg ? ST_INV : ST_SHR;
    wire logic [IDX_W-1:0] cur_idx =
        cur_reg.addr[LINE_LO+IDX_W-1:LINE_LO];
    wire logic [TAG_W-1:0] cur_tag = cur_reg.addr[ADDR_HI:LINE_LO+IDX_W];
    assign wr_idx = wr_inv ? snp_idx : (wr_busy ? cur_idx : mark_i.idx);
    assign wr_line = wr_inv ? '{tag: rd_line.tag, smm: rd_line.smm,
            state: ST_INV} :
        (wb_done ? '{tag: cur_tag, smm: cur_reg.smm, state: wb_state} :
        (fill_install ? '{tag: cur_tag, smm: cur_reg.smm,
            state: fill_state} :
        '{tag: mark_i.tag, smm: mark_i.smm, state: ST_MOD}));

    bbsc_line_mem #(
        .W(LINE_W),
        .DEPTH(DEPTH),
        .AW(IDX_W)
    ) u_line_mem (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .rd_addr_i(pins_s_reg.addr[LINE_LO+IDX_W-1:LINE_LO]),
        .rd_data_o(rd_line),
        .wr_en_i(wr_inv || wb_done || fill_install || wr_mark),
        .wr_addr_i(wr_idx),
        .wr_data_i(wr_line)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SQ_IDLE: begin
                if (take_any) begin
                    state_next = SQ_SETUP;
                end
            end
            SQ_SETUP: begin
                if (back_off_request_s) begin
                    state_next = SQ_IDLE;
                end else if (cur_reg.wb || !addr_float_request_s) begin
                    state_next = SQ_ADDR;
                end
            end
            SQ_ADDR: begin
                state_next = back_off_request_s ? SQ_IDLE : SQ_DATA;
            end
            SQ_DATA: begin
                if (back_off_request_s || last_beat) begin
                    state_next = SQ_IDLE;
                end
            end
            default: begin
                state_next = SQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= SQ_IDLE;
            cur_reg <= '0;
            saved_reg <= '0;
            smm_level_reg <= SMM_RST;
        end else begin
            state_reg <= state_next;
            if (take_any) begin
                cur_reg <= load_cyc;
                smm_level_reg <= load_cyc.smm;
            end
            if (abort) begin
                saved_reg <= cur_reg;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            beat_reg <= BEAT_FIRST;
            burst_reg <= 1'b0;
            policy_reg <= 1'b0;
            restart_reg <= 1'b0;
        end else begin
            if (take_any || abort) begin
                beat_reg <= BEAT_FIRST;
            end else if (data_beat) begin
                beat_reg <= beat_reg + BEAT_ONE;
            end
            if (data_beat && first_beat) begin
                burst_reg <= burst_now;
                policy_reg <= pins_s_reg.write_policy;
            end
            if (abort) begin
                restart_reg <= 1'b1;
            end else if (take_restart) begin
                restart_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            snp1_reg <= 1'b0;
            snp_addr_reg <= '0;
            snp_inv_reg <= 1'b0;
            snp_par_reg <= 1'b0;
            match_reg <= 1'b0;
            par_fault_reg <= 1'b0;
        end else begin
            snp1_reg <= snoop_take;
            if (snoop_take) begin
                snp_addr_reg <= pins_s_reg.addr;
                snp_inv_reg <= pins_s_reg.drop_line;
                snp_par_reg <= par_err;
            end
            if (snp1_reg) begin
                match_reg <= snoop_any;
            end
            par_fault_reg <= snp1_reg && snp_par_reg;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dirty_reg <= 1'b0;
            wb_pend_reg <= 1'b0;
            wb_line_reg <= '0;
            wb_smm_reg <= 1'b0;
            wb_drop_reg <= 1'b0;
            fill_snooped_reg <= 1'b0;
            fill_drop_reg <= 1'b0;
        end else begin
            if (hit_mod) begin
                dirty_reg <= 1'b1;
                wb_pend_reg <= 1'b1;
                wb_line_reg <= snp_addr_reg;
                wb_smm_reg <= rd_line.smm;
                wb_drop_reg <= snp_inv_reg;
            end else begin
                if (wb_done) begin
                    dirty_reg <= 1'b0;
                end
                if (take_wb) begin
                    wb_pend_reg <= 1'b0;
                end
                if (wbuf_hit && snp_inv_reg) begin
                    wb_drop_reg <= 1'b1;
                end
            end
            if (take_req) begin
                fill_snooped_reg <= 1'b0;
                fill_drop_reg <= 1'b0;
            end else if (fill_hit) begin
                fill_snooped_reg <= 1'b1;
                fill_drop_reg <= fill_drop;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_valid_reg <= 1'b0;
            rd_data_reg <= '0;
            data_out_reg <= '0;
        end else begin
            // fill words reach the core even if the line is later lost
            rd_valid_reg <= data_beat && !cur_reg.write;
            if (data_beat) begin
                rd_data_reg <= pins_s_reg.data;
            end
            data_out_reg <= wr_data_i;
        end
    end

    assign cyc_req_ready_o = (state_reg == SQ_IDLE) && bus_free &&
        !addr_float_request_s && !wb_pend_reg && !restart_reg;
    assign cyc_done_o = last_beat && !cur_reg.wb;
    assign mark_ready_o = !wr_busy;
    assign beat_o = beat_reg;
    assign rd_valid_o = rd_valid_reg;
    assign rd_data_o = rd_data_reg;
    assign address_strobe_b_o = !((state_reg == SQ_ADDR) && ctl_oe_o);
    assign addr_o = cur_reg.addr;
    assign addr_oe_o = bus_free &&
        (!addr_float_request_s || (cur_reg.wb && in_cycle));
    assign ctl_oe_o = bus_free;
    assign data_o = data_out_reg;
    assign data_oe_o = bus_free && cur_reg.write && (state_reg == SQ_DATA);
    assign sys_mgmt_active_b_o = !smm_level_reg;
    assign sys_mgmt_oe_o = bus_free;
    assign snoop_match_b_o = !match_reg;
    assign snoop_match_dirty_b_o = !dirty_reg;
    assign addr_parity_fault_b_o = !par_fault_reg;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_back_off_request_float;
        back_off_request_s |-> !ctl_oe_o && !addr_oe_o && address_strobe_b_o;
    endproperty
    a_back_off_request_float: assert property (p_back_off_request_float)
        else $error("bus not floated under back-off");

    property p_restart;
        abort |=> restart_reg && state_reg == SQ_IDLE &&
            saved_reg == $past(cur_reg);
    endproperty
    a_restart: assert property (p_restart)
        else $error("aborted cycle not kept for re-run");

    property p_burst_ready_ignored;
        (state_reg == SQ_DATA && back_off_request_s && burst_ready_s) |=> !rd_valid_o &&
            $stable(rd_data_o);
    endproperty
    a_burst_ready_ignored: assert property (p_burst_ready_ignored)
        else $error("ready taken during back-off");

    property p_no_install_abort;
        (fill_install) |-> !back_off_request_s && (beat_reg == BEAT_LAST);
    endproperty
    a_no_install_abort: assert property (p_no_install_abort)
        else $error("line installed without full fill");

    property p_dirty_answer;
        (snoop_take && !dirty_reg) ##1 hit_mod |=> !snoop_match_b_o &&
            !snoop_match_dirty_b_o;
    endproperty
    a_dirty_answer: assert property (p_dirty_answer)
        else $error("dirty hit not answered in second clock");

    property p_dirty_hold;
        (dirty_reg && !wb_done) |=> dirty_reg && !snp1_reg;
    endproperty
    a_dirty_hold: assert property (p_dirty_hold)
        else $error("dirty dropped early or snoop accepted");

    property p_wb_qw0;
        (state_reg == SQ_ADDR && cur_reg.wb) |-> addr_o[QW_LO+1:QW_LO] == '0;
    endproperty
    a_wb_qw0: assert property (p_wb_qw0)
        else $error("write-back not at quadword zero");

    property p_wb_ads;
        ($rose(dirty_reg) && state_reg == SQ_IDLE && !restart_reg &&
            bus_free) ##1 bus_free |=> !address_strobe_b_o;
    endproperty
    a_wb_ads: assert property (p_wb_ads)
        else $error("write-back strobe not two clocks after dirty");

    property p_smm_setup;
        !address_strobe_b_o |-> $stable(sys_mgmt_active_b_o) &&
            $past(state_reg) == SQ_SETUP;
    endproperty
    a_smm_setup: assert property (p_smm_setup)
        else $error("management level not set a clock early");

    property p_fill_idle;
        (last_beat && !cur_reg.write) |=> address_strobe_b_o;
    endproperty
    a_fill_idle: assert property (p_fill_idle)
        else $error("no idle clock after fill");

    property p_parity;
        (snoop_take && par_err) |-> ##2 !addr_parity_fault_b_o;
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity fault not flagged");

    property p_smm_float;
        bus_hold |-> !sys_mgmt_oe_o;
    endproperty
    a_smm_float: assert property (p_smm_float)
        else $error("management pin driven in bus hold");
endmodule // bbsc_core

// >>> core/bbsc_line_mem.sv
// line state and tag store with registered read data
`timescale 1ns/1ps
module bbsc_line_mem #(
    parameter int W = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [W-1:0] rd_data_o,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [W-1:0] wr_data_i
);
    logic [W-1:0] rd_mux [DEPTH];
    logic [W-1:0] rd_data_reg;

    for (genvar g = 0; g < DEPTH; g++) begin : g_ent
        logic [W-1:0] ent_reg;
        wire logic hit_wr = wr_en_i && (wr_addr_i == AW'(g));
        always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                ent_reg <= '0;
            end else if (hit_wr) begin
                ent_reg <= wr_data_i;
            end
        end
        assign rd_mux[g] = ent_reg;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= rd_mux[rd_addr_i];
        end
    end

    assign rd_data_o = rd_data_reg;
endmodule // bbsc_line_mem

// >>> core/bbsc_pkg.sv
// shared constants and types for the bus back-off and snoop control block
package bbsc_pkg;
    localparam int ADDR_HI = 31;
    localparam int LINE_LO = 5;
    localparam int QW_LO = 3;
    localparam int IDX_W = 4;
    localparam int LINE_ADDR_W = ADDR_HI - LINE_LO + 1;
    localparam int TAG_W = LINE_ADDR_W - IDX_W;
    localparam int DEPTH = 16;
    localparam int DATA_W = 64;
    localparam int BEAT_W = 2;
    localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;
    localparam logic [BEAT_W-1:0] BEAT_ONE = 2'h1;
    localparam logic [QW_LO+1:QW_LO] WB_START_QW = 2'h0;
    localparam logic [1:0] ST_INV = 2'h0;
    localparam logic [1:0] ST_SHR = 2'h1;
    localparam logic [1:0] ST_EXC = 2'h2;
    localparam logic [1:0] ST_MOD = 2'h3;
    localparam logic SMM_RST = 1'b0;

    typedef struct packed {
        logic [TAG_W-1:0] tag;
        logic smm;
        logic [1:0] state;
    } bbsc_line_type;

    localparam int LINE_W = $bits(bbsc_line_type);

    typedef struct packed {
        logic [ADDR_HI:QW_LO] addr;
        logic write;
        logic smm;
    } bbsc_req_type;

    typedef struct packed {
        logic [ADDR_HI:QW_LO] addr;
        logic write;
        logic smm;
        logic wb;
    } bbsc_cyc_type;

    typedef struct packed {
        logic [IDX_W-1:0] idx;
        logic [TAG_W-1:0] tag;
        logic smm;
    } bbsc_mark_type;

    typedef struct packed {
        logic back_off_b;
        logic burst_ready_b;
        logic addr_float;
        logic snoop_strobe_b;
        logic drop_line;
        logic cacheable_b;
        logic write_policy;
        logic parity_bit;
        logic [ADDR_HI:LINE_LO] addr;
        logic [DATA_W-1:0] data;
    } bbsc_pin_type;

    typedef enum logic [1:0] {
        SQ_IDLE,
        SQ_SETUP,
        SQ_ADDR,
        SQ_DATA
    } bbsc_seq_type;
endpackage

// >>> test/bbsc_core_test.sv
// self-checking bench for the back-off and snoop control block
`timescale 1ns/1ps
module bbsc_core_test;
    import bbsc_pkg::*;
    localparam logic [DATA_W-1:0] BASE = 64'h0123456789abcd00;
    localparam logic [ADDR_HI:LINE_LO] LA = 27'h0123450;
    localparam logic [ADDR_HI:LINE_LO] LB = 27'h0123451;
    localparam logic [ADDR_HI:LINE_LO] LM = 27'h0234562;
    logic ref_clk_i, rst_b_i, grant, req_v, mark_v, bo_b, af, ss_b, drop;
    logic par, rdy_b, cach_b, wpol, req_rdy, done, mark_rdy, rd_v, as_b;
    logic aoe, coe, sm_b, smoe, hit_b, dirty_b, pf_b, smm_before;
    logic [ADDR_HI:LINE_LO] saddr;
    logic [DATA_W-1:0] bdata, rd_data;
    logic [ADDR_HI:QW_LO] addr;
    logic [1:0] wait_sel;
    bbsc_pin_type pins;
    bbsc_req_type req;
    bbsc_mark_type mark;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_rd = 0;
    int n_done = 0;
    int cycles = 0;
    assign pins = {bo_b, rdy_b, af, ss_b, drop, cach_b, wpol, par, saddr, bdata};
    bbsc_core i_bbsc_core (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .pins_i(pins), .bus_release_grant_i(grant), .cyc_req_valid_i(req_v),
        .cyc_req_i(req), .cyc_req_ready_o(req_rdy), .cyc_done_o(done),
        .mark_valid_i(mark_v), .mark_i(mark), .mark_ready_o(mark_rdy),
        .wr_data_i(BASE), .beat_o(), .rd_valid_o(rd_v), .rd_data_o(rd_data),
        .address_strobe_b_o(as_b), .addr_o(addr), .addr_oe_o(aoe),
        .ctl_oe_o(coe), .data_o(), .data_oe_o(), .sys_mgmt_active_b_o(sm_b),
        .sys_mgmt_oe_o(smoe), .snoop_match_b_o(hit_b),
        .snoop_match_dirty_b_o(dirty_b), .addr_parity_fault_b_o(pf_b));
    bbsc_sys_model #(.BASE(BASE)) i_bbsc_sys_model (.ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i), .strobe_b_i(as_b), .back_off_b_i(bo_b),
        .wait_i(wait_sel), .rdy_b_o(rdy_b), .data_o(bdata), .cach_b_o(cach_b),
        .wpol_o(wpol));
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // level one clock before a strobe is kept for the strobe cycle
    always @(negedge ref_clk_i) begin
        cycles++;
        if (rd_v === 1'b1) n_rd++;
        if (done === 1'b1) n_done++;
        if (as_b === 1'b1) smm_before = sm_b;
        if (cycles == 4000) begin
            n_mismatch++;
            conclude();
        end
    end
    task check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask
    task check_word(input string what, input logic [63:0] exp,
                    input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task cycles_n(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task push(input logic mk, input logic [ADDR_HI:QW_LO] a, input logic smm);
        int k;
        @(negedge ref_clk_i);
        req <= '{addr: a, write: 1'b0, smm: smm};
        mark <= '{idx: a[LINE_LO+IDX_W-1:LINE_LO],
                  tag: a[ADDR_HI:LINE_LO+IDX_W], smm: smm};
        if (mk) mark_v <= 1'b1;
        else req_v <= 1'b1;
        #1;
        for (k = 0; k < 40 && (mk ? mark_rdy : req_rdy) !== 1'b1; k++) begin
            @(negedge ref_clk_i);
            #1;
        end
        @(negedge ref_clk_i);
        {req_v, mark_v} <= 2'h0;
    endtask
    task wait_strobe;
        int k;
        @(negedge ref_clk_i);
        for (k = 0; k < 40 && as_b !== 1'b0; k++) @(negedge ref_clk_i);
        check_bit("address strobe", 1'b0, as_b);
    endtask
    task wait_done(input int d0);
        int k;
        for (k = 0; k < 80 && n_done == d0; k++) @(negedge ref_clk_i);
        check_word("cycle done", 64'(d0 + 1), 64'(n_done));
        cycles_n(3);
    endtask
    task floated;
        check_bit("ctl oe", 1'b0, coe);
        check_bit("addr oe", 1'b0, aoe);
        check_bit("mgmt oe", 1'b0, smoe);
    endtask
    task snoop(input logic [ADDR_HI:LINE_LO] line, input logic dr,
               input logic bad, input logic e_hit, input logic e_dirty);
        logic seen;
        seen = 1'b0;
        @(negedge ref_clk_i);
        saddr <= line;
        drop <= dr;
        par <= ^line ^ bad;
        ss_b <= 1'b0;
        @(negedge ref_clk_i);
        ss_b <= 1'b1;
        repeat (8) begin
            @(negedge ref_clk_i);
            if (pf_b === 1'b0) seen = 1'b1;
        end
        check_bit("snoop match", e_hit, hit_b);
        check_bit("snoop dirty", e_dirty, dirty_b);
        check_bit("parity fault", bad, seen);
    endtask
    task test_abort;
        int k;
        int r0;
        int d0;
        r0 = n_rd;
        d0 = n_done;
        push(1'b0, {LM, 2'h1}, 1'b1);
        wait_strobe();
        check_bit("mgmt before cycle", 1'b0, smm_before);
        for (k = 0; k < 20 && rdy_b !== 1'b0; k++) @(posedge ref_clk_i);
        // back-off lands together with the second beat
        @(negedge ref_clk_i) bo_b <= 1'b0;
        cycles_n(4);
        floated();
        cycles_n(2);
        bo_b <= 1'b1;
        wait_strobe();
        check_word("rerun addr", {35'h0, LM, 2'h1}, {35'h0, addr});
        wait_done(d0);
        check_word("rerun beats", 64'h5, 64'(n_rd - r0));
        check_word("rerun data", BASE | 64'h3, rd_data);
    endtask
    task test_fill;
        int r0;
        int d0;
        r0 = n_rd;
        d0 = n_done;
        wait_sel <= 2'h2;
        push(1'b0, {LA, 2'h0}, 1'b1);
        wait_strobe();
        check_word("fill addr", {35'h0, LA, 2'h0}, {35'h0, addr});
        wait_done(d0);
        check_word("fill beats", 64'h4, 64'(n_rd - r0));
        push(1'b1, {LA, 2'h0}, 1'b0);
    endtask
    task test_snoop;
        int k;
        wait_sel <= 2'h1;
        @(negedge ref_clk_i) bo_b <= 1'b0;
        cycles_n(4);
        floated();
        snoop(LA, 1'b0, 1'b0, 1'b0, 1'b0);
        snoop(LB, 1'b0, 1'b0, 1'b0, 1'b0);
        @(negedge ref_clk_i) bo_b <= 1'b1;
        wait_strobe();
        check_word("wb addr", {35'h0, LA, 2'h0}, {35'h0, addr});
        check_bit("wb mgmt", 1'b1, smm_before);
        for (k = 0; k < 40 && dirty_b !== 1'b1; k++) @(negedge ref_clk_i);
        check_bit("dirty released", 1'b1, dirty_b);
        @(negedge ref_clk_i) af <= 1'b1;
        cycles_n(3);
        snoop(LA, 1'b0, 1'b1, 1'b0, 1'b1);
        snoop(LA, 1'b1, 1'b0, 1'b0, 1'b1);
        @(negedge ref_clk_i) af <= 1'b0;
        grant <= 1'b1;
        cycles_n(3);
        snoop(LA, 1'b0, 1'b0, 1'b1, 1'b1);
        @(negedge ref_clk_i) grant <= 1'b0;
        push(1'b1, {LA, 2'h0}, 1'b1);
        @(negedge ref_clk_i) af <= 1'b1;
        cycles_n(3);
        snoop(LA, 1'b1, 1'b0, 1'b0, 1'b0);
        check_bit("wb mgmt smm", 1'b0, smm_before);
        for (k = 0; k < 40 && dirty_b !== 1'b1; k++) @(negedge ref_clk_i);
        check_bit("dirty released", 1'b1, dirty_b);
        snoop(LA, 1'b0, 1'b0, 1'b1, 1'b1);
    endtask
    initial begin
        rst_b_i = 1'b0;
        {grant, req_v, mark_v, af, drop, par, wait_sel} = '0;
        {bo_b, ss_b} = 2'h3;
        req = '0;
        mark = '0;
        saddr = '0;
        repeat (8) @(posedge ref_clk_i);
        check_bit("reset strobe", 1'b1, as_b);
        check_bit("reset dirty", 1'b1, dirty_b);
        @(negedge ref_clk_i) rst_b_i <= 1'b1;
        cycles_n(4);
        test_abort();
        test_fill();
        test_snoop();
        conclude();
    end
endmodule // bbsc_core_test

// >>> test/bbsc_sys_model.sv
// system side model: burst ready and read data for each address strobe
`timescale 1ns/1ps
module bbsc_sys_model
    import bbsc_pkg::*;
#(
    parameter logic [DATA_W-1:0] BASE = 64'h0
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic strobe_b_i,
    input wire logic back_off_b_i,
    input wire logic [1:0] wait_i,
    output logic rdy_b_o,
    output logic [DATA_W-1:0] data_o,
    output logic cach_b_o,
    output logic wpol_o
);
    logic [2:0] left;
    logic [1:0] gap;
    // fixed level, so a re-run cycle sees what the first try saw
    assign cach_b_o = 1'b0;
    assign wpol_o = 1'b1;
    // idle data toggles so a stale beat never looks valid
    always @(negedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            left <= 3'h0;
            gap <= 2'h0;
            rdy_b_o <= 1'b1;
            data_o <= BASE;
        end else if (left != 3'h0 && gap == 2'h0 && back_off_b_i) begin
            rdy_b_o <= 1'b0;
            data_o <= BASE | 64'(3'h4 - left);
            left <= left - 3'h1;
            gap <= wait_i;
        end else begin
            rdy_b_o <= 1'b1;
            data_o <= ~data_o;
            if (!back_off_b_i) begin
                left <= 3'h0;
            end else if (!strobe_b_i) begin
                left <= 3'h4;
                gap <= wait_i;
            end else if (gap != 2'h0) begin
                gap <= gap - 2'h1;
            end
        end
    end
endmodule // bbsc_sys_model
